// ---- card_ident_and_access_params.sv ----
// card identity record and access-parameter record with program path
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a 128-bit identity record is offered on identityRecord for identification
// - identity record comes from factory inputs; no host path alters it
// - serial number is a per-device factory input, unique per device
// - identity fields packed maker, application, name, revision, serial, date
// - identity ends with computed checksum then a constant one bit
// - access record top two bits hold layout version 1.0
// - program command alters only the programmable low entries
// - read-only access entries always come from factory inputs
// - format group, copy, permanent lock, format change only once
// - temporary lock, bits 9:8 and checksum accept repeated programming
// - read access time and read access clocks fields placed as documented
// - transfer rate code and command class mask placed as documented
// - read and write block length codes placed as documented
// - partial read, misalign and partial write flags placed as documented
// - bit 76 shows whether driver-stage register is present
// - capacity, four current codes and multiplier placed as documented
// - single-block erase enable and sector size placed as documented
// - protect group size, group enable and write speed factor placed
// - access checksum in bits 7:1, bit 0 always one
// - records held in registers that drive the record outputs; reloaded every clock from factory inputs, checksums and programmed entries
module card_ident_and_access_params (
    input  wire logic         clock,
    input  wire logic         reset_n,
    input  wire logic [7:0]   makerCode,
    input  wire logic [15:0]  application_code,
    input  wire logic [39:0]  product_name_text,
    input  wire logic [7:0]   product_revision_bcd,
    input  wire logic [31:0]  serial_number,
    input  wire logic [11:0]  manufacture_date_bcd,
    input  wire logic [7:0]   read_access_time,
    input  wire logic [7:0]   read_access_clocks,
    input  wire logic [7:0]   transferRate,
    input  wire logic [11:0]  command_class_mask,
    input  wire logic [3:0]   read_block_length,
    input  wire logic         partial_read_allowed,
    input  wire logic         write_misalign_allowed,
    input  wire logic         read_misalign_allowed,
    input  wire logic         driver_stage_present,
    input  wire logic [11:0]  capacityCount,
    input  wire logic [2:0]   read_current_low_supply,
    input  wire logic [2:0]   read_current_high_supply,
    input  wire logic [2:0]   write_current_low_supply,
    input  wire logic [2:0]   write_current_high_supply,
    input  wire logic [2:0]   capacity_multiplier,
    input  wire logic         single_block_erase_enable,
    input  wire logic [6:0]   sectorSize,
    input  wire logic [6:0]   protect_group_size,
    input  wire logic         protect_group_enable,
    input  wire logic [2:0]   write_speed_factor,
    input  wire logic [3:0]   write_block_length,
    input  wire logic         partial_write_allowed,
    input  wire logic         progRequest,
    input  wire logic [15:0]  progData,
    output logic              progBusy,
    output logic              progDone,
    output logic              ready,
    output logic [127:0]      identityRecord,
    output logic [127:0]      accessRecord
);
    import card_regs_pkg::*;

    typedef struct packed {
        prog_state_t  phase;
        logic         recordSel;
        logic [7:0]   bitCount;
        logic [15:0]  programmed;
        logic [4:0]   onceUsed;
        logic [15:0]  pendingData;
        logic         pendingValid;
        logic [6:0]   identityCrc;
        logic [6:0]   accessCrc;
        logic         ready;
        logic         done;
        logic [127:0] identityOut;
        logic [127:0] accessOut;
    } top_state_t;

    top_state_t   state;
    top_state_t   next_state;
    logic [127:0] identityBody;
    logic [127:0] accessBody;
    logic [127:0] shiftSource;
    logic [15:0]  mergedProg;
    logic [15:0]  onceBits;
    logic [4:0]   newlyUsed;

    crc_bus_if crcLink();

    crc7_unit checksum (
        .clock   (clock),
        .reset_n (reset_n),
        .link    (crcLink)
    );

    // identity record built from factory-fixed inputs only
    always_comb begin
        identityBody = '0;
        identityBody[MAKER_LSB +: 8]   = makerCode;
        identityBody[APP_LSB +: 16]    = application_code;
        identityBody[NAME_LSB +: 40]   = product_name_text;
        identityBody[REV_LSB +: 8]     = product_revision_bcd;
        identityBody[SERIAL_LSB +: 32] = serial_number;
        identityBody[DATE_LSB +: 12]   = manufacture_date_bcd;
    end

    // access record: read-only fields straight from factory inputs
    always_comb begin
        accessBody = '0;
        accessBody[VERSION_LSB +: 2]     = LAYOUT_V1;
        accessBody[ACCESS_TIME_LSB +: 8] = read_access_time;
        accessBody[ACCESS_CLK_LSB +: 8]  = read_access_clocks;
        accessBody[RATE_LSB +: 8]        = transferRate;
        accessBody[CLASS_LSB +: 12]      = command_class_mask;
        accessBody[RD_BLK_LSB +: 4]      = read_block_length;
        accessBody[RD_PART_BIT]          = partial_read_allowed;
        accessBody[WR_MIS_BIT]           = write_misalign_allowed;
        accessBody[RD_MIS_BIT]           = read_misalign_allowed;
        accessBody[DRIVER_BIT]           = driver_stage_present;
        accessBody[CAP_LSB +: 12]        = capacityCount;
        accessBody[CURRENT_LSB +: 12]    = {read_current_low_supply,
                                            read_current_high_supply,
                                            write_current_low_supply,
                                            write_current_high_supply};
        accessBody[CAP_MULT_LSB +: 3]    = capacity_multiplier;
        accessBody[ERASE_EN_BIT]         = single_block_erase_enable;
        accessBody[SECTOR_LSB +: 7]      = sectorSize;
        accessBody[GROUP_SIZE_LSB +: 7]  = protect_group_size;
        accessBody[GROUP_EN_BIT]         = protect_group_enable;
        accessBody[SPEED_LSB +: 3]       = write_speed_factor;
        accessBody[WR_BLK_LSB +: 4]      = write_block_length;
        accessBody[WR_PART_BIT]          = partial_write_allowed;
        accessBody[15:0]                 = state.programmed & ~16'h0001;
    end

    // once-only bits gathered into a vector matching onceUsed
    always_comb begin
        onceBits  = ONCE_MASK;
        newlyUsed = {state.pendingData[FMT_GROUP_BIT]
                     ^ state.programmed[FMT_GROUP_BIT],
                     state.pendingData[COPY_BIT]
                     ^ state.programmed[COPY_BIT],
                     state.pendingData[PERM_LOCK_BIT]
                     ^ state.programmed[PERM_LOCK_BIT],
                     state.pendingData[FMT_LSB +: 2]
                     != state.programmed[FMT_LSB +: 2],
                     1'b0};
        mergedProg = (state.pendingData & REPEAT_MASK)
            | (state.programmed & ~REPEAT_MASK);
        if (!state.onceUsed[4]) begin
            mergedProg[FMT_GROUP_BIT] = state.pendingData[FMT_GROUP_BIT];
        end
        if (!state.onceUsed[3]) begin
            mergedProg[COPY_BIT] = state.pendingData[COPY_BIT];
        end
        if (!state.onceUsed[2]) begin
            mergedProg[PERM_LOCK_BIT] = state.pendingData[PERM_LOCK_BIT];
        end
        if (!state.onceUsed[1]) begin
            mergedProg[FMT_LSB +: 2] = state.pendingData[FMT_LSB +: 2];
        end
        mergedProg = mergedProg & (onceBits | REPEAT_MASK);
    end

    assign shiftSource = state.recordSel ? accessBody : identityBody;

    always_comb begin
        next_state = state;
        next_state.done = 1'b0;
        crcLink.start    = 1'b0;
        crcLink.bitValid = 1'b0;
        crcLink.bitIn    = shiftSource[RECORD_WIDTH - 1 - state.bitCount];
        // program requests are latched and served between checksum passes
        if (progRequest && !state.pendingValid) begin
            next_state.pendingValid = 1'b1;
            next_state.pendingData  = progData;
        end
        case (state.phase)
            IDLE: begin
                crcLink.start = 1'b1;
                next_state.bitCount = 8'h00;
                next_state.phase    = SHIFT;
            end
            SHIFT: begin
                crcLink.bitValid = 1'b1;
                if (state.bitCount == 8'(BODY_WIDTH - 1)) begin
                    next_state.phase = APPLY;
                end else begin
                    next_state.bitCount = state.bitCount + 8'h01;
                end
            end
            APPLY: begin
                if (state.recordSel) begin
                    next_state.accessCrc = crcLink.crc;
                    next_state.ready     = 1'b1;
                    if (state.pendingValid) begin
                        next_state.programmed   = mergedProg;
                        next_state.onceUsed     = state.onceUsed
                                                 | newlyUsed;
                        next_state.pendingValid = 1'b0;
                        next_state.done         = 1'b1;
                    end
                end else begin
                    next_state.identityCrc = crcLink.crc;
                end
                next_state.recordSel = ~state.recordSel;
                next_state.phase     = IDLE;
            end
            default: begin
                next_state.phase = IDLE;
            end
        endcase
        next_state.identityOut = {identityBody[127:8],
                                  state.identityCrc, 1'b1};
        next_state.accessOut = {accessBody[127:8],
                                accessBody[7:1] == 7'h00 ?
                                state.accessCrc : accessBody[7:1],
                                1'b1};
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '{phase: IDLE, recordSel: 1'b0, bitCount: 8'h00,
                       programmed: PROG_RESET, onceUsed: USED_RESET,
                       pendingData: 16'h0000, pendingValid: 1'b0,
                       identityCrc: 7'h00, accessCrc: 7'h00,
                       ready: 1'b0, done: 1'b0,
                       identityOut: '0, accessOut: '0};
        end else begin
            state <= next_state;
        end
    end

    assign identityRecord = state.identityOut;
    assign accessRecord   = state.accessOut;
    assign progBusy       = state.pendingValid;
    assign progDone       = state.done;
    assign ready          = state.ready;
endmodule
`default_nettype wire

// ---- card_regs_pkg.sv ----
// constants and field layout of the card identity and access-parameter records
package card_regs_pkg;
    localparam int RECORD_WIDTH = 128;
    localparam int CHECK_WIDTH  = 7;
    localparam int BODY_WIDTH   = 120;
    localparam int OTP_WIDTH    = 5;

    // identity record field positions (low bit of each field)
    localparam int MAKER_LSB       = 120;
    localparam int APP_LSB         = 104;
    localparam int NAME_LSB        = 64;
    localparam int REV_LSB         = 56;
    localparam int SERIAL_LSB      = 24;
    localparam int DATE_LSB        = 8;
    localparam int CHECK_LSB       = 1;

    // access-parameter record field positions
    localparam int VERSION_LSB     = 126;
    localparam int ACCESS_TIME_LSB = 112;
    localparam int ACCESS_CLK_LSB  = 104;
    localparam int RATE_LSB        = 96;
    localparam int CLASS_LSB       = 84;
    localparam int RD_BLK_LSB      = 80;
    localparam int RD_PART_BIT     = 79;
    localparam int WR_MIS_BIT      = 78;
    localparam int RD_MIS_BIT      = 77;
    localparam int DRIVER_BIT      = 76;
    localparam int CAP_LSB         = 62;
    localparam int CURRENT_LSB     = 50;
    localparam int CAP_MULT_LSB    = 47;
    localparam int ERASE_EN_BIT    = 46;
    localparam int SECTOR_LSB      = 39;
    localparam int GROUP_SIZE_LSB  = 32;
    localparam int GROUP_EN_BIT    = 31;
    localparam int SPEED_LSB       = 26;
    localparam int WR_BLK_LSB      = 22;
    localparam int WR_PART_BIT     = 21;
    localparam int FMT_GROUP_BIT   = 15;
    localparam int COPY_BIT        = 14;
    localparam int PERM_LOCK_BIT   = 13;
    localparam int TEMP_LOCK_BIT   = 12;
    localparam int FMT_LSB         = 10;
    localparam int SPARE_LSB       = 8;

    localparam logic [1:0] LAYOUT_V1 = 2'h0;
    localparam logic [6:0] CHECK_POLY = 7'h09;

    // programmable low byte pair: once-only bits and repeat bits
    localparam logic [15:0] ONCE_MASK   = 16'hEC00;
    localparam logic [15:0] REPEAT_MASK = 16'h13FE;
    localparam logic [15:0] PROG_RESET  = 16'h0000;
    localparam logic [4:0]  USED_RESET  = 5'h00;

    localparam int LOAD_CYCLES = 128;

    typedef enum logic [1:0] {
        IDLE    = 2'b00,
        SHIFT   = 2'b01,
        APPLY   = 2'b11
    } prog_state_t;
endpackage

// ---- crc_bus_if.sv ----
// interface carrying a serial checksum request and its result
`timescale 1ns/1ps
`default_nettype none
interface crc_bus_if;
    logic       start;
    logic       bitValid;
    logic       bitIn;
    logic [6:0] crc;
    modport gen  (input start, bitValid, bitIn, output crc);
    modport user (output start, bitValid, bitIn, input crc);
endinterface
`default_nettype wire

// ---- crc7_unit.sv ----
// serial seven-bit checksum over a bit stream, generator x^7+x^3+1
`timescale 1ns/1ps
`default_nettype none
module crc7_unit (
    input  wire logic clock,
    input  wire logic reset_n,
    crc_bus_if.gen    link
);
    import card_regs_pkg::*;

    typedef struct packed {
        logic [6:0] crc;
    } crc_state_t;

    crc_state_t state;
    crc_state_t next_state;
    logic       feedback;

    always_comb begin
        next_state = state;
        feedback   = state.crc[6] ^ link.bitIn;
        if (link.start) begin
            next_state.crc = 7'h00;
        end else if (link.bitValid) begin
            next_state.crc = {state.crc[5:0], 1'b0}
                ^ (feedback ? CHECK_POLY : 7'h00);
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign link.crc = state.crc;
endmodule
`default_nettype wire

// ---- card_regs_asserts.sv ----
// port-level checks on the card record block
`timescale 1ns/1ps
`default_nettype none
module card_regs_asserts (
    input wire logic         clock,
    input wire logic         reset_n,
    input wire logic [7:0]   makerCode,
    input wire logic [31:0]  serial_number,
    input wire logic [7:0]   read_access_time,
    input wire logic [11:0]  capacityCount,
    input wire logic         progRequest,
    input wire logic         progBusy,
    input wire logic         progDone,
    input wire logic         ready,
    input wire logic [127:0] identityRecord,
    input wire logic [127:0] accessRecord
);
    import card_regs_pkg::*;
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    property p_idTail; ready |-> identityRecord[0]
        && identityRecord[23:20] == 4'h0; endproperty
    a_idTail: assert property (p_idTail)
        else $error("identity tail bits wrong");
    property p_idFields; ready |-> identityRecord[127:120] == makerCode
        && identityRecord[55:24] == serial_number; endproperty
    a_idFields: assert property (p_idFields)
        else $error("identity fields misplaced");
    property p_idFixed; ready ##1 ready |-> $stable(identityRecord); endproperty
    a_idFixed: assert property (p_idFixed)
        else $error("identity record changed");
    property p_accTop; ready |-> accessRecord[127:120] == {LAYOUT_V1, 6'h00}
        && accessRecord[0]; endproperty
    a_accTop: assert property (p_accTop)
        else $error("access version or tail wrong");
    property p_accRo; ready |-> accessRecord[119:112] == read_access_time
        && accessRecord[73:62] == capacityCount; endproperty
    a_accRo: assert property (p_accRo)
        else $error("access fields misplaced");
    property p_take; progRequest && !progBusy |=> progBusy; endproperty
    a_take: assert property (p_take)
        else $error("request not taken");
    property p_doneBound; $rose(progBusy) |-> ##[1:300] progDone; endproperty
    a_doneBound: assert property (p_doneBound)
        else $error("program never completed");
    property p_roKeep; progDone |=> !progDone
        && $stable(accessRecord[127:16]); endproperty
    a_roKeep: assert property (p_roKeep)
        else $error("done too long or read-only part changed");
endmodule
bind card_ident_and_access_params card_regs_asserts u_chk (.*);
`default_nettype wire

// ---- card_host_model.sv ----
// host model issuing program commands to the access record
`timescale 1ns/1ps
`default_nettype none
module card_host_model (
    input  wire logic        clock,
    input  wire logic        progBusy,
    input  wire logic        progDone,
    output var  logic        progRequest,
    output var  logic [15:0] progData
);
    initial begin
        progRequest = 1'b0;
        progData    = 16'h0000;
    end
    // optional stray request while busy must be ignored
    task automatic prog_cmd(input logic [15:0] d, input bit intrude,
                            output bit ok);
        ok = 1'b0;
        @(posedge clock);
        progRequest <= 1'b1;
        progData    <= d;
        @(posedge clock);
        progRequest <= 1'b0;
        progData    <= ~d;
        if (intrude) begin
            @(posedge clock);
            progRequest <= 1'b1;
            @(posedge clock);
            progRequest <= 1'b0;
        end
        for (int n = 0; n < 400 && !ok; n++) begin
            @(posedge clock);
            ok = (progDone === 1'b1);
        end
    endtask
endmodule
`default_nettype wire

// ---- card_ident_and_access_params_tb.sv ----
// self-checking bench for the card record block
`timescale 1ns/1ps
`default_nettype none
module card_ident_and_access_params_tb;
    import card_regs_pkg::*;
    logic         clock, reset_n, ready, progBusy, progDone, progRequest;
    logic [15:0]  progData, prog, used, application_code;
    logic [127:0] identityRecord, accessRecord;
    logic [7:0]   makerCode, product_revision_bcd, read_access_time;
    logic [7:0]   read_access_clocks, transferRate;
    logic [39:0]  product_name_text;
    logic [31:0]  serial_number;
    logic [11:0]  manufacture_date_bcd, command_class_mask, capacityCount;
    logic [3:0]   read_block_length, write_block_length;
    logic         partial_read_allowed, write_misalign_allowed;
    logic         read_misalign_allowed, driver_stage_present;
    logic [2:0]   read_current_low_supply, read_current_high_supply;
    logic [2:0]   write_current_low_supply, write_current_high_supply;
    logic [2:0]   capacity_multiplier, write_speed_factor;
    logic         single_block_erase_enable, protect_group_enable;
    logic [6:0]   sectorSize, protect_group_size;
    logic         partial_write_allowed;
    int           fails, cmp_count, cycles;
    bit           ok;

    card_ident_and_access_params DUT (.*);
    card_host_model host (.clock(clock), .progBusy(progBusy),
        .progDone(progDone), .progRequest(progRequest), .progData(progData));

    always #12.5 clock = ~clock;

    function automatic logic [6:0] crc7(input logic [119:0] b);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            c = (b[i] ^ c[6]) ? ({c[5:0], 1'b0} ^ 7'h09) : {c[5:0], 1'b0};
        end
        return c;
    endfunction
    function automatic logic [119:0] accBody();
        return {LAYOUT_V1, 6'h00, read_access_time, read_access_clocks,
            transferRate, command_class_mask, read_block_length,
            partial_read_allowed, write_misalign_allowed,
            read_misalign_allowed, driver_stage_present, 2'h0, capacityCount,
            read_current_low_supply, read_current_high_supply,
            write_current_low_supply, write_current_high_supply,
            capacity_multiplier, single_block_erase_enable, sectorSize,
            protect_group_size, protect_group_enable, 2'h0,
            write_speed_factor, write_block_length, partial_write_allowed,
            5'h00, prog[15:8]};
    endfunction
    function automatic logic [127:0] idExp();
        logic [119:0] b;
        b = {makerCode, application_code, product_name_text,
            product_revision_bcd, serial_number, 4'h0, manufacture_date_bcd};
        return {b, crc7(b), 1'b1};
    endfunction
    function automatic logic [127:0] accExp();
        return {accBody(), (prog[7:1] != 7'h00) ? prog[7:1] : crc7(accBody()),
            1'b1};
    endfunction
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // once-only bits lock after their first change, repeat bits always take
    task automatic apply(input logic [15:0] d, input bit intrude);
        logic [15:0] once;
        once = ONCE_MASK & ~used;
        host.prog_cmd(d, intrude, ok);
        check({127'h0, ok}, 128'h1);
        used = used | (once & (d ^ prog));
        // the two file-format bits lock together as one field
        if (used[FMT_LSB +: 2] != 2'b00) used[FMT_LSB +: 2] = 2'b11;
        prog = (prog & ONCE_MASK & ~once) | (d & once) | (d & REPEAT_MASK);
        @(negedge clock);
        check(accessRecord[127:8], accBody());
        repeat (300) @(posedge clock);
        @(negedge clock);
        check(accessRecord, accExp());
        $display("test program %h done", d);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    always @(posedge clock) begin
        cycles++;
        if (cycles == 6000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        clock = 1'b0;
        reset_n = 1'b0;
        {prog, used} = 32'h0;
        {makerCode, application_code, product_name_text, product_revision_bcd}
            = {8'h5A, 16'h4F41, 40'h4352445831, 8'h12};
        {serial_number, manufacture_date_bcd} = {32'hC0DE1234, 12'h0B5};
        {read_access_time, read_access_clocks, transferRate} = 24'h260A32;
        {command_class_mask, read_block_length, write_block_length} =
            20'h5B59A;
        capacityCount = 12'hA6F;
        {partial_read_allowed, write_misalign_allowed, read_misalign_allowed,
            driver_stage_present} = 4'hA;
        {read_current_low_supply, read_current_high_supply,
            write_current_low_supply, write_current_high_supply} = 12'h6B5;
        {capacity_multiplier, write_speed_factor, sectorSize,
            protect_group_size} = {3'h5, 3'h2, 7'h3F, 7'h41};
        {single_block_erase_enable, protect_group_enable,
            partial_write_allowed} = 3'h5;
        repeat (4) @(posedge clock);
        reset_n <= 1'b1;
        for (int n = 0; n < 1000 && ready !== 1'b1; n++) @(posedge clock);
        @(negedge clock);
        check(identityRecord, idExp());
        check(accessRecord, accExp());
        $display("test reset records done");
        apply(16'h5402, 1'b0);
        apply(16'hA900, 1'b0);
        apply(16'h0000, 1'b1);
        check(identityRecord, idExp());
        conclude();
    end
endmodule
`default_nettype wire
